// >>> tb/fifo_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_dev_model
  import fifo_host_pkg::*;
#(
  parameter int DEPTH = 512
)
(
  input  wire logic        wr_strobe_n,
  input  wire logic        rd_strobe_n,
  input  wire logic [8:0]  d,
  output logic      [8:0]  q,
  output logic             q_oe,
  input  wire logic        master_clear_n,
  input  wire logic        rewind_read_n,
  input  wire logic        token_in,
  output logic             token_out,
  output lane_flags_t      flags
);
  logic [8:0] mem [DEPTH];
  int         wp = 0;
  int         rp = 0;
  int         cnt = 0;
  logic       solo = 1'b1;
  logic       wtok = 1'b0;
  logic       rtok = 1'b0;
  time        t_wr = 0;

  initial begin
    q = 9'h0;
    q_oe = 1'b0;
    token_out = 1'b1;
  end

  assign flags = {
    cnt != DEPTH,
    !(cnt > DEPTH / 2),
    cnt != 0
  };

  task automatic pass_token();
    token_out <= 1'b0;
    token_out <= #5 1'b1;
  endtask : pass_token

  // Mode and first-load are read when the clear ends
  always @(posedge master_clear_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    solo = !token_in;
    wtok = !rewind_read_n;
    rtok = !rewind_read_n;
  end

  always @(posedge wr_strobe_n) begin
    t_wr = $time;
    if (master_clear_n && (solo || wtok) && cnt < DEPTH) begin
      mem[wp] = d;
      wp = (wp + 1) % DEPTH;
      cnt++;
      if (!solo && wp == 0) begin
        wtok = 1'b0;
        pass_token();
      end
    end
  end

  // Token kind told apart by which strobe just rose
  always @(negedge token_in) begin
    if ($time == t_wr)
      wtok = (cnt < DEPTH);
    else
      rtok = 1'b1;
  end

  always @(negedge rd_strobe_n) begin
    if ((solo || rtok) && cnt > 0) begin
      q = mem[rp];
      q_oe = 1'b1;
    end
  end

  always @(posedge rd_strobe_n) begin
    if (q_oe) begin
      rp = (rp + 1) % DEPTH;
      cnt--;
      if (!solo && rp == 0) begin
        rtok = 1'b0;
        pass_token();
      end
    end
    q_oe = 1'b0;
    q = ~q;  // Released bus must not look held
  end

  always @(negedge rewind_read_n) begin
    if (solo) begin
      rp = 0;
      if (cnt != DEPTH)
        cnt = wp;
    end
  end
endmodule : fifo_dev_model
`default_nettype wire

// >>> tb/fifo_host_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_host_tb_top
  import fifo_host_pkg::*;
;
  localparam int DEP = 512;
  logic                    ref_clk = 1'b0;
  logic                    sys_rst = 1'b1;
  logic [3:0]              bus_addr = 4'h0;
  logic [31:0]             bus_wdata = 32'h0;
  logic                    bus_wr = 1'b0;
  logic                    bus_rd = 1'b0;
  logic [31:0]             bus_rdata;
  logic                    wr_strobe_n;
  logic                    rd_strobe_n;
  logic [WORD_W-1:0]       fifo_d;
  wire  logic [WORD_W-1:0] fifo_q;
  logic                    master_clear_n;
  logic [LANES-1:0]        rewind_read_n;
  logic [LANES-1:0]        token_in;
  wire  logic [LANES-1:0]  token_out;
  wire  lane_flags_t [LANES-1:0] lane_flags;
  wire  logic [8:0]        q0;
  wire  logic [8:0]        q1;
  wire  logic [1:0]        q_oe;
  int                      mismatches = 0;
  int                      tests_run = 0;
  int                      hist[$];
  logic [31:0]             v;
  logic [31:0]             dmode = 32'h0;

  always #(CLK_NS / 2) ref_clk = ~ref_clk;

  fifo_host dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .wr_strobe_n(wr_strobe_n),
    .rd_strobe_n(rd_strobe_n), .fifo_d(fifo_d), .fifo_q(fifo_q),
    .master_clear_n(master_clear_n), .rewind_read_n(rewind_read_n),
    .token_in(token_in), .token_out(token_out), .lane_flags(lane_flags)
  );
  fifo_dev_model #(.DEPTH(DEP)) dev0_u (
    .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n), .d(fifo_d[8:0]),
    .q(q0), .q_oe(q_oe[0]), .master_clear_n(master_clear_n),
    .rewind_read_n(rewind_read_n[0]), .token_in(token_in[0]),
    .token_out(token_out[0]), .flags(lane_flags[0])
  );
  fifo_dev_model #(.DEPTH(DEP)) dev1_u (
    .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n), .d(fifo_d[17:9]),
    .q(q1), .q_oe(q_oe[1]), .master_clear_n(master_clear_n),
    .rewind_read_n(rewind_read_n[1]), .token_in(token_in[1]),
    .token_out(token_out[1]), .flags(lane_flags[1])
  );
  // Depth mode shares lane 0 of the data bus between both devices
  assign fifo_q = {q1, (q_oe[1] && !q_oe[0]) ? q1 : q0};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic bus_write(input logic [3:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= wd;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [3:0] a, output logic [31:0] rd);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    @(posedge ref_clk);
    rd = bus_rdata;
  endtask : bus_read

  task automatic wait_idle(input logic [31:0] mask);
    int n = 0;
    v = mask;
    while ((v & mask) !== 32'h0) begin
      bus_read(ADDR_STAT, v);
      n++;
      if (n > 60) begin
        check(v & mask, 32'h0);
        end_sim();
      end
    end
  endtask : wait_idle

  task automatic push(input int w);
    bus_write(ADDR_DATA, 32'(w));
    wait_idle(32'h1);
  endtask : push

  task automatic pop(input int exp);
    wait_idle(32'h2);
    bus_write(ADDR_CTRL, 32'h1 | dmode);
    wait_idle(32'h2);
    check(32'(v[STAT_RVALID]), 32'h1);
    bus_read(ADDR_DATA, v);
    check(v, 32'(exp));
  endtask : pop

  task automatic stat(input logic e, input logic h, input logic f);
    bus_read(ADDR_STAT, v);
    check(32'(v[4:2]), 32'({f, h, e}));
  endtask : stat

  always @(posedge ref_clk)
    if (!sys_rst && rewind_read_n == 2'b00)
      check(32'({token_in, rd_strobe_n}), 32'h1);

  initial begin
    void'($urandom(70302));
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus_read(4'hc, v);
    check(v, 32'h0);
    bus_write(ADDR_CTRL, 32'h4);
    wait_idle(32'h3);
    stat(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < DEP; i++) begin
      hist.push_back($urandom & 32'h3ffff);
      push(hist[i]);
      stat(1'b0, i + 1 > DEP / 2, i + 1 == DEP);
    end
    push(32'h15a);
    check(32'(v[STAT_WREF]), 32'h1);
    bus_write(ADDR_STAT, 32'h20);
    bus_write(ADDR_CTRL, 32'h2);
    wait_idle(32'h2);
    stat(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < DEP; i++)
      pop(hist[i]);
    stat(1'b1, 1'b0, 1'b0);
    bus_write(ADDR_CTRL, 32'h1);
    bus_read(ADDR_STAT, v);
    check(32'(v[STAT_RREF]), 32'h1);
    bus_write(ADDR_CTRL, 32'h4);
    wait_idle(32'h3);
    hist.delete();
    for (int i = 0; i < 6; i++)
      hist.push_back($urandom & 32'h3ffff);
    for (int i = 0; i < 4; i++)
      push(hist[i]);
    pop(hist[0]);
    pop(hist[1]);
    // First write issued while the rewind recovery runs, the second after it ends
    bus_write(ADDR_CTRL, 32'h2);
    push(hist[4]);
    push(hist[5]);
    for (int i = 0; i < 6; i++)
      pop(hist[i]);
    bus_write(ADDR_CTRL, 32'h2);
    for (int i = 0; i < 6; i++)
      pop(hist[i]);
    dmode = 32'h8;
    bus_write(ADDR_CTRL, 32'hc);
    wait_idle(32'h3);
    hist.delete();
    for (int i = 0; i < DEP + 2; i++) begin
      hist.push_back($urandom & 32'h1ff);
      push(hist[i]);
    end
    stat(1'b0, 1'b1, 1'b0);
    bus_write(ADDR_STAT, 32'h40);
    bus_read(ADDR_STAT, v);
    check(32'(v[STAT_RREF]), 32'h0);
    // Rewind in a chain must be refused and leave the data in place
    bus_write(ADDR_CTRL, 32'ha);
    bus_read(ADDR_STAT, v);
    check(32'(v[STAT_RREF]), 32'h1);
    for (int i = 0; i < DEP + 2; i++)
      pop(hist[i]);
    stat(1'b1, 1'b0, 1'b0);
    end_sim();
  end
endmodule : fifo_host_tb_top
`default_nettype wire

// >>> verilog/fifo_host.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_host
  import fifo_host_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic [3:0]                bus_addr,
  input  wire logic [31:0]               bus_wdata,
  input  wire logic                      bus_wr,
  input  wire logic                      bus_rd,
  output logic      [31:0]               bus_rdata,
  output logic                           wr_strobe_n,
  output logic                           rd_strobe_n,
  output logic      [WORD_W-1:0]         fifo_d,
  input  wire logic [WORD_W-1:0]         fifo_q,
  output logic                           master_clear_n,
  output logic      [LANES-1:0]          rewind_read_n,
  output logic      [LANES-1:0]          token_in,
  input  wire logic [LANES-1:0]          token_out,
  input  wire lane_flags_t [LANES-1:0]   lane_flags
);

  logic [3*LANES-1:0]     fl_s1_r, fl_s2_r, fl_s3_r, fl_db_r;
  lane_flags_t [LANES-1:0] db_v;
  logic [LANES-1:0]       empty_v, half_v, full_v;
  comp_flags_t            comp;
  logic [WORD_W-1:0]      q_s1_r, q_s2_r, q_s3_r;
  logic                   depth_r;
  wr_state_t              w_state_r, w_nxt;
  rd_state_t              r_state_r, r_nxt;
  logic [3:0]             w_cnt_r, r_cnt_r;
  logic [WORD_W-1:0]      d_r, rd_word_r;
  logic                   rd_n_r, rt_n_r, mr_n_r, wr_n_r;
  logic                   wref_r, rref_r, rvalid_r;
  logic                   wr_cmd, rd_cmd, rt_cmd, mr_cmd, ctrl_wr;
  logic                   w_take, r_take, rt_take, mr_take, capture;

  // Flags arrive from another timing world: three stages, agree on two
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fl_s1_r <= {LANES{LANE_FLAGS_RST}};
      fl_s2_r <= {LANES{LANE_FLAGS_RST}};
      fl_s3_r <= {LANES{LANE_FLAGS_RST}};
      fl_db_r <= {LANES{LANE_FLAGS_RST}};
    end else begin
      fl_s1_r <= lane_flags;
      fl_s2_r <= fl_s1_r;
      fl_s3_r <= fl_s2_r;
      fl_db_r <= (fl_s2_r & fl_s3_r) | (fl_db_r & (fl_s2_r ^ fl_s3_r));
    end
  end

  assign db_v = fl_db_r;

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      // Flags on the pins are active low
      assign empty_v[gi] = ~db_v[gi].no_data_flag;
      assign half_v[gi]  = ~db_v[gi].half_flag_n;
      assign full_v[gi]  = ~db_v[gi].no_room_flag;
      // Depth use closes the ring, otherwise the token pin is held low
      assign token_in[gi] = depth_r &
        token_out[(gi + LANES - 1) % LANES];
      // Same pin: first-load select in depth use, rewind otherwise
      assign rewind_read_n[gi] = depth_r ? (gi != 0)
                                         : rt_n_r;
    end
  endgenerate

  // Side by side any lane decides; in a chain empty and full need all devices, half any one
  always_comb begin
    if (depth_r) begin
      comp.empty = &empty_v;
      comp.full  = &full_v;
      comp.half  = |half_v;
    end else begin
      comp.empty = |empty_v;
      comp.full  = |full_v;
      comp.half  = |half_v;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_s1_r <= '0;
      q_s2_r <= '0;
      q_s3_r <= '0;
    end else begin
      q_s1_r <= fifo_q;
      q_s2_r <= q_s1_r;
      q_s3_r <= q_s2_r;
    end
  end

  assign ctrl_wr = bus_wr && (bus_addr == ADDR_CTRL);
  assign wr_cmd  = bus_wr && (bus_addr == ADDR_DATA);
  assign mr_cmd  = ctrl_wr && bus_wdata[CTRL_CLEAR];
  assign rt_cmd  = ctrl_wr && bus_wdata[CTRL_REWIND] && !mr_cmd;
  assign rd_cmd  = ctrl_wr && bus_wdata[CTRL_READ] && !mr_cmd && !rt_cmd;

  // Writes may run beside a rewind, but never beside a master clear
  assign w_take  = wr_cmd && w_state_r == W_IDLE && !comp.full &&
                   r_state_r != MR_LOW && r_state_r != MR_HIGH;
  assign mr_take = mr_cmd && r_state_r == R_IDLE && w_state_r == W_IDLE;
  assign rt_take = rt_cmd && r_state_r == R_IDLE && !depth_r;
  assign r_take  = rd_cmd && r_state_r == R_IDLE && !comp.empty;
  assign capture = r_state_r == R_LOW && r_cnt_r == 4'h0;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      depth_r <= DEPTH_RST;
    end else if (ctrl_wr) begin
      depth_r <= bus_wdata[CTRL_DEPTH];
    end
  end

  always_comb begin
    w_nxt = w_state_r;
    unique case (w_state_r)
      W_IDLE: if (w_take) w_nxt = W_LOW;
      W_LOW:  if (w_cnt_r == 4'h0) w_nxt = W_HIGH;
      W_HIGH: if (w_cnt_r == 4'h0) w_nxt = W_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      w_state_r <= W_IDLE;
      w_cnt_r   <= 4'h0;
      wr_n_r    <= 1'b1;
    end else begin
      w_state_r <= w_nxt;
      // Strobe from a flop only, so the pin never carries a glitch
      wr_n_r    <= (w_nxt != W_LOW);
      if (w_state_r != w_nxt) begin
        w_cnt_r <= (w_nxt == W_LOW) ? WR_LOW_CYC - 4'h1
                                    : WR_HIGH_CYC - 4'h1;
      end else if (w_cnt_r != 4'h0) begin
        w_cnt_r <= w_cnt_r - 4'h1;
      end
    end
  end

  // Data loaded on the same edge as the fall, held until after the rising edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      d_r <= '0;
    end else if (w_take) begin
      d_r <= depth_r ? {LANES{bus_wdata[LANE_W-1:0]}}
                     : bus_wdata[WORD_W-1:0];
    end
  end

  always_comb begin
    r_nxt = r_state_r;
    unique case (r_state_r)
      R_IDLE: begin
        if (mr_take) r_nxt = MR_LOW;
        else if (rt_take) r_nxt = RT_LOW;
        else if (r_take) r_nxt = R_LOW;
      end
      R_LOW:   if (r_cnt_r == 4'h0) r_nxt = R_HIGH;
      R_HIGH:  if (r_cnt_r == 4'h0) r_nxt = R_IDLE;
      RT_LOW:  if (r_cnt_r == 4'h0) r_nxt = RT_HIGH;
      RT_HIGH: if (r_cnt_r == 4'h0) r_nxt = R_IDLE;
      MR_LOW:  if (r_cnt_r == 4'h0) r_nxt = MR_HIGH;
      MR_HIGH: if (r_cnt_r == 4'h0) r_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      r_state_r <= R_IDLE;
      r_cnt_r   <= 4'h0;
    end else begin
      r_state_r <= r_nxt;
      if (r_state_r != r_nxt) begin
        unique case (r_nxt)
          R_LOW:   r_cnt_r <= RD_LOW_CYC - 4'h1;
          R_HIGH:  r_cnt_r <= RD_HIGH_CYC - 4'h1;
          RT_LOW:  r_cnt_r <= RT_LOW_CYC - 4'h1;
          RT_HIGH: r_cnt_r <= RT_HIGH_CYC - 4'h1;
          MR_LOW:  r_cnt_r <= MR_LOW_CYC - 4'h1;
          MR_HIGH: r_cnt_r <= MR_HIGH_CYC - 4'h1;
          R_IDLE:  r_cnt_r <= 4'h0;
        endcase
      end else if (r_cnt_r != 4'h0) begin
        r_cnt_r <= r_cnt_r - 4'h1;
      end
    end
  end

  // One engine owns read, rewind and clear, so they never overlap
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_n_r <= 1'b1;
      rt_n_r <= 1'b1;
      mr_n_r <= 1'b1;
    end else begin
      rd_n_r <= (r_nxt != R_LOW);
      rt_n_r <= (r_nxt != RT_LOW);
      mr_n_r <= (r_nxt != MR_LOW);
    end
  end

  // Depth use shares one output bus, seen on lane 0
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_word_r <= '0;
    end else if (capture) begin
      rd_word_r <= depth_r ? {{(WORD_W-LANE_W){1'b0}}, q_s3_r[LANE_W-1:0]}
                           : q_s3_r;
    end
  end

  // Sticky bits: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wref_r   <= 1'b0;
      rref_r   <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      if (wr_cmd && !w_take) wref_r <= 1'b1;
      else if (bus_wr && bus_addr == ADDR_STAT && bus_wdata[STAT_WREF])
        wref_r <= 1'b0;
      if ((mr_cmd && !mr_take) || (rt_cmd && !rt_take) ||
          (rd_cmd && !r_take)) rref_r <= 1'b1;
      else if (bus_wr && bus_addr == ADDR_STAT && bus_wdata[STAT_RREF])
        rref_r <= 1'b0;
      if (capture) rvalid_r <= 1'b1;
      else if (bus_rd && bus_addr == ADDR_DATA) rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_rdata <= '0;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADDR_DATA: bus_rdata <= {{(32-WORD_W){1'b0}}, rd_word_r};
        ADDR_CTRL: bus_rdata <= {28'h0, depth_r, 3'h0};
        ADDR_STAT: bus_rdata <= {24'h0, rvalid_r, rref_r, wref_r,
                                 comp.full, comp.half, comp.empty,
                                 r_state_r != R_IDLE, w_state_r != W_IDLE};
        default:   bus_rdata <= '0;
      endcase
    end else begin
      bus_rdata <= '0;
    end
  end

  assign wr_strobe_n    = wr_n_r;
  assign rd_strobe_n    = rd_n_r;
  assign master_clear_n = mr_n_r;
  assign fifo_d         = d_r;

  sequence s_wr_rec;
    wr_strobe_n [*5];
  endsequence

  sequence s_rt_quiet;
    rd_strobe_n [*2];
  endsequence

  property p_word_lanes;
    @(posedge ref_clk) disable iff (sys_rst)
      depth_r && $fell(wr_strobe_n) |->
        fifo_d == {LANES{fifo_d[LANE_W-1:0]}};
  endproperty
  a_word_lanes: assert property (p_word_lanes)
    else $error("depth lanes not replicated");

  property p_token_low;
    @(posedge ref_clk) disable iff (sys_rst)
      !depth_r && r_state_r != RT_LOW |->
        token_in == '0 && &rewind_read_n;
  endproperty
  a_token_low: assert property (p_token_low)
    else $error("token or first-load pin wrong outside depth use");

  property p_width_empty;
    @(posedge ref_clk) disable iff (sys_rst)
      !depth_r && |empty_v && rd_cmd && r_state_r == R_IDLE |=>
        r_state_r == R_IDLE && rd_strobe_n;
  endproperty
  a_width_empty: assert property (p_width_empty)
    else $error("read started while a lane was empty");

  property p_first_one;
    @(posedge ref_clk) disable iff (sys_rst)
      depth_r |-> $onehot(~rewind_read_n) && !rewind_read_n[0];
  endproperty
  a_first_one: assert property (p_first_one)
    else $error("first-load not on exactly one device");

  property p_ring;
    @(posedge ref_clk) disable iff (sys_rst)
      depth_r |->
        token_in == {token_out[LANES-2:0], token_out[LANES-1]};
  endproperty
  a_ring: assert property (p_ring)
    else $error("token ring miswired");

  property p_chain_read;
    @(posedge ref_clk) disable iff (sys_rst)
      depth_r && !(&empty_v) && rd_cmd && r_state_r == R_IDLE |=>
        !rd_strobe_n;
  endproperty
  a_chain_read: assert property (p_chain_read)
    else $error("chain read refused while data present");

  property p_rt_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
      $fell(rt_n_r) |-> s_rt_quiet;
  endproperty
  a_rt_quiet: assert property (p_rt_quiet)
    else $error("read strobe active during rewind");

  property p_wr_clean;
    @(posedge ref_clk) disable iff (sys_rst)
      $rose(wr_strobe_n) |-> $stable(fifo_d) ##0 s_wr_rec;
  endproperty
  a_wr_clean: assert property (p_wr_clean)
    else $error("write data moved or strobe glitched");

  property p_full_block;
    @(posedge ref_clk) disable iff (sys_rst)
      comp.full && wr_cmd && w_state_r == W_IDLE |=>
        wr_strobe_n && wref_r;
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("write issued while full");

endmodule : fifo_host
`default_nettype wire

// >>> verilog/fifo_host_pkg.sv
// What this block does
// - Wider words come from side-by-side devices, nine bits each.
// - Single or width use: token input held low, first-load held high.
// - Side-by-side flags are combined into composite word flags.
// - Depth chain: exactly one device has first-load tied low.
// - Depth chain: token outputs feed next token input, closing a ring.
// - Depth chain: composite empty and full reflect the whole chain, half is set by any one device.
// - Read strobe stays inactive throughout a rewind pulse.
package fifo_host_pkg;

  localparam int LANES  = 2;
  localparam int LANE_W = 9;
  localparam int WORD_W = LANES * LANE_W;

  localparam int CLK_NS        = 20;
  localparam int T_GLITCH_NS   = 3;
  localparam int T_WR_PULSE_NS = 20;
  localparam int T_WR_REC_NS   = 10;
  localparam int T_ACCESS_NS   = 20;
  localparam int T_RD_REC_NS   = 10;
  localparam int T_RT_PULSE_NS = 20;
  localparam int T_RT_REC_NS   = 20;
  localparam int T_MR_PULSE_NS = 20;
  localparam int T_MR_REC_NS   = 20;
  localparam int SYNC_CYC      = 3;
  localparam int SETTLE_CYC    = SYNC_CYC + 1;

  localparam logic [3:0] WR_LOW_CYC =
    4'((T_WR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WR_HIGH_CYC =
    4'((T_WR_REC_NS + CLK_NS - 1) / CLK_NS + SETTLE_CYC);
  localparam logic [3:0] RD_LOW_CYC =
    4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC + 1);
  localparam logic [3:0] RD_HIGH_CYC =
    4'((T_RD_REC_NS + CLK_NS - 1) / CLK_NS + SETTLE_CYC);
  localparam logic [3:0] RT_LOW_CYC =
    4'((T_RT_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RT_HIGH_CYC =
    4'((T_RT_REC_NS + CLK_NS - 1) / CLK_NS + SETTLE_CYC);
  localparam logic [3:0] MR_LOW_CYC =
    4'((T_MR_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] MR_HIGH_CYC =
    4'((T_MR_REC_NS + CLK_NS - 1) / CLK_NS + SETTLE_CYC);

  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;

  localparam int CTRL_READ   = 0;
  localparam int CTRL_REWIND = 1;
  localparam int CTRL_CLEAR  = 2;
  localparam int CTRL_DEPTH  = 3;

  localparam int STAT_WBUSY  = 0;
  localparam int STAT_RBUSY  = 1;
  localparam int STAT_EMPTY  = 2;
  localparam int STAT_HALF   = 3;
  localparam int STAT_FULL   = 4;
  localparam int STAT_WREF   = 5;
  localparam int STAT_RREF   = 6;
  localparam int STAT_RVALID = 7;

  localparam logic DEPTH_RST = 1'b0;

  typedef struct packed {
    logic no_room_flag;
    logic half_flag_n;
    logic no_data_flag;
  } lane_flags_t;

  typedef struct packed {
    logic full;
    logic half;
    logic empty;
  } comp_flags_t;

  localparam lane_flags_t LANE_FLAGS_RST = '{
    no_room_flag: 1'b1, half_flag_n: 1'b1, no_data_flag: 1'b0};

  typedef enum logic [1:0] {W_IDLE, W_LOW, W_HIGH} wr_state_t;
  typedef enum logic [2:0] {
    R_IDLE, R_LOW, R_HIGH, RT_LOW, RT_HIGH, MR_LOW, MR_HIGH
  } rd_state_t;

endpackage : fifo_host_pkg
